/* File: rtl/rmb_ctrl.sv */
/*
  mode and busy controller: decodes the two select pins, drives the busy
  indicator and defers mode changes until pending work is done.
  assumes the radio, uart and parameter store sit outside and give strobes.
*/
`include "rmb_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module rmb_ctrl (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic mode_select_low_i,
  input wire logic mode_select_high_i,
  input wire logic [15:0] own_addr_i,
  input wire logic host_wr_i,
  input wire logic radio_take_i,
  input wire logic rx_out_active_i,
  input wire logic cfg_req_i,
  output logic host_ready_o,
  output logic busy_n_o,
  output logic [1:0] mode_o,
  output logic sleep_o,
  output logic cfg_awake_o,
  output logic reload_o,
  output logic [8:0] tx_level_o,
  output logic bcast_tx_o,
  output logic monitor_rx_o,
  output logic filter_en_o,
  output logic [15:0] cfg_baud_o
);
  // ==================================================
  // declarations
  localparam int SW_CYC = `RMB_SWITCH_CYC;
  localparam int ST_CYC = `RMB_SETTLE_CYC;
  rmb_pkg::rmb_state_e state_r;
  rmb_pkg::rmb_mode_e mode_r;
  rmb_pkg::rmb_busy_s busy_s;
  rmb_pkg::rmb_addr_s addr_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] target_r;
  logic [15:0] cnt_r;
  logic [15:0] high_cnt_r;
  logic busy_n_r;
  logic busy_n_nxt;
  logic [8:0] level;
  logic tx_pend;
  logic work_done;
  // every check below runs on the rising clock and is dropped while reset is low
  default clocking chk_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ==================================================
  // helpers
  // decode the synchronised pin pair to a mode
  function automatic rmb_pkg::rmb_mode_e decode_mode(input logic [1:0] pins);
    decode_mode = rmb_pkg::rmb_mode_e'(pins);
  endfunction

  // ==================================================
  // transmit buffer occupancy
  rmb_tx_level u_tx_level (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(host_wr_i),
    .rd_i(radio_take_i),
    .ready_o(host_ready_o),
    .level_o(level)
  );
  assign tx_level_o = level;
  assign tx_pend = (level != 9'h000) || host_wr_i;

  // ==================================================
  // pin synchroniser, two stages
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
    end else begin
      pin_s1_r <= {mode_select_high_i, mode_select_low_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ==================================================
  // busy combination: low if any busy condition holds
  assign busy_s.init = (state_r == rmb_pkg::RMB_ST_SELFCHK) ||
    (state_r == rmb_pkg::RMB_ST_RELOAD);
  assign busy_s.tx_pend = tx_pend;
  assign busy_s.rx_out = rx_out_active_i;
  assign busy_n_nxt = ~(|busy_s);
  assign work_done = ~busy_s.tx_pend && ~busy_s.rx_out;

  // busy high only says the buffer drained, the last packet may still be on air
  // registered busy so the host sees no glitches; no done flag is made from it
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_n_r <= 1'b0;
    end else begin
      busy_n_r <= busy_n_nxt;
    end
  end
  assign busy_n_o = busy_n_r;

  // time busy has stayed high, saturating
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_cnt_r <= 16'h0000;
    end else if (!busy_n_r) begin
      high_cnt_r <= 16'h0000;
    end else if (high_cnt_r < 16'(ST_CYC)) begin
      high_cnt_r <= high_cnt_r + 16'h0001;
    end
  end

  // ==================================================
  // mode state machine
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= rmb_pkg::RMB_ST_SELFCHK;
      mode_r <= rmb_pkg::rmb_mode_e'(`RMB_MODE_RST);
      target_r <= 2'h0;
      cnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        rmb_pkg::RMB_ST_SELFCHK: begin
          // self-check then apply stored parameters, busy held low
          if (cnt_r == 16'(`RMB_SELFCHK_CYC - 1)) begin
            state_r <= rmb_pkg::RMB_ST_RUN;
            mode_r <= decode_mode(pin_s2_r);
            cnt_r <= 16'h0000;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        rmb_pkg::RMB_ST_RUN: begin
          // pins are only looked at while busy is high
          if (busy_n_r && (pin_s2_r != mode_r)) begin
            target_r <= pin_s2_r;
            state_r <= rmb_pkg::RMB_ST_SWITCH;
            cnt_r <= 16'h0000;
          end
        end
        rmb_pkg::RMB_ST_SWITCH: begin
          if (!work_done || pin_s2_r != target_r) begin
            // new work or a new request restarts the wait
            target_r <= pin_s2_r;
            cnt_r <= 16'h0000;
          end else if (cnt_r >= 16'(SW_CYC - 2) &&
                       (high_cnt_r >= 16'(ST_CYC) || high_cnt_r >= cnt_r)) begin
            // idle switch after 1ms; after a fresh rise wait 2ms of high
            if (mode_r == rmb_pkg::RMB_MODE_SLEEP &&
                target_r != 2'(rmb_pkg::RMB_MODE_SLEEP)) begin
              state_r <= rmb_pkg::RMB_ST_RELOAD;
            end else begin
              state_r <= rmb_pkg::RMB_ST_RUN;
            end
            mode_r <= decode_mode(target_r);
            cnt_r <= 16'h0000;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        rmb_pkg::RMB_ST_RELOAD: begin
          if (cnt_r == 16'(`RMB_RELOAD_CYC - 1)) begin
            state_r <= rmb_pkg::RMB_ST_RUN;
            cnt_r <= 16'h0000;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        default: begin
          state_r <= rmb_pkg::RMB_ST_SELFCHK;
          cnt_r <= 16'h0000;
        end
      endcase
    end
  end

  // ==================================================
  // mode outputs
  assign mode_o = mode_r;
  assign reload_o = busy_s.init;
  assign sleep_o = (mode_r == rmb_pkg::RMB_MODE_SLEEP) && !cfg_req_i;
  assign cfg_awake_o = (mode_r == rmb_pkg::RMB_MODE_SLEEP) && cfg_req_i;
  assign cfg_baud_o = 16'(`RMB_CFG_BAUD);

  // ==================================================
  // address filtering decision, registered
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_r <= '0;
    end else begin
      addr_r.bcast_tx <= (own_addr_i == `RMB_ADDR_ALL_ONES);
      addr_r.monitor_rx <= (own_addr_i == `RMB_ADDR_ALL_ONES) ||
        (own_addr_i == `RMB_ADDR_ALL_ZERO);
      addr_r.filter_en <= (own_addr_i != `RMB_ADDR_ALL_ONES);
    end
  end
  assign bcast_tx_o = addr_r.bcast_tx;
  assign monitor_rx_o = addr_r.monitor_rx;
  assign filter_en_o = addr_r.filter_en;

  // ==================================================
  // checks
  // busy conditions
  a_busy_tx_pend: assert property (
    (level != 9'h000) |=> !busy_n_o)
    else $error("busy high with buffer data");

  a_busy_rx_out: assert property (
    rx_out_active_i |=> !busy_n_o)
    else $error("busy high during serial output");

  a_busy_and_all: assert property (
    (!busy_s.init && level == 9'h000 && !host_wr_i && !rx_out_active_i) |=> busy_n_o)
    else $error("busy low with no cause");

  a_busy_host_wr: assert property (
    host_wr_i |=> !busy_n_o)
    else $error("busy high while host streams");

  a_busy_init_low: assert property (
    (state_r == rmb_pkg::RMB_ST_SELFCHK) |=> !busy_n_o)
    else $error("busy high in self-check");

  a_reload_low: assert property (
    (state_r == rmb_pkg::RMB_ST_RELOAD) |=> !busy_n_o)
    else $error("busy high in reload");

  // mode switching
  a_mode_stable_busy: assert property (
    (!busy_n_o && state_r == rmb_pkg::RMB_ST_RUN) |=> $stable(mode_o))
    else $error("mode changed while busy");

  a_run_holds_busy: assert property (
    (state_r == rmb_pkg::RMB_ST_RUN && !busy_n_r) |=> (state_r == rmb_pkg::RMB_ST_RUN))
    else $error("pins looked at while busy");

  a_mode_settle: assert property (
    ($changed(mode_o) && $past(state_r) == rmb_pkg::RMB_ST_SWITCH) |->
    ($past(high_cnt_r) >= 16'(SW_CYC - 2)))
    else $error("mode changed too early");

  a_mode_decode: assert property (
    (state_r == rmb_pkg::RMB_ST_SELFCHK && cnt_r == 16'(`RMB_SELFCHK_CYC - 1)) |=>
    (mode_o == $past(pin_s2_r)))
    else $error("start mode differs from pins");

  a_switch_target: assert property (
    ($past(state_r) == rmb_pkg::RMB_ST_SWITCH && $changed(mode_o)) |->
    (mode_o == $past(target_r)))
    else $error("switched to wrong mode");

  a_switch_hold_work: assert property (
    (state_r == rmb_pkg::RMB_ST_SWITCH && !work_done) |=>
    (state_r == rmb_pkg::RMB_ST_SWITCH && $stable(mode_o)))
    else $error("switch taken with work pending");

  a_switch_done: assert property (
    (state_r == rmb_pkg::RMB_ST_SWITCH && work_done && pin_s2_r == target_r &&
    cnt_r >= 16'(SW_CYC - 2) && high_cnt_r >= 16'(ST_CYC)) |=> (state_r != rmb_pkg::RMB_ST_SWITCH))
    else $error("switch not taken when due");

  a_sleep_entry: assert property (
    (state_r == rmb_pkg::RMB_ST_SWITCH && target_r == 2'h3 && !work_done) |=>
    (mode_o == $past(mode_o)))
    else $error("slept with data pending");

  a_sleep_exit_reload: assert property (
    ($past(state_r) == rmb_pkg::RMB_ST_SWITCH && $past(mode_r) == rmb_pkg::RMB_MODE_SLEEP &&
    mode_r != rmb_pkg::RMB_MODE_SLEEP) |-> (state_r == rmb_pkg::RMB_ST_RELOAD))
    else $error("sleep left without reload");

  // mode outputs and buffer
  a_sleep_out: assert property (
    (mode_o == 2'h3 && !cfg_req_i) |-> (sleep_o && !cfg_awake_o))
    else $error("not asleep in sleep mode");

  a_cfg_wake: assert property (
    (mode_o == 2'h3 && cfg_req_i) |-> (cfg_awake_o && !sleep_o))
    else $error("no wake for configuration");

  a_awake_only_sleep: assert property (
    (mode_o != 2'h3) |-> (!sleep_o && !cfg_awake_o))
    else $error("sleep flags outside sleep mode");

  a_baud_fixed: assert property (
    cfg_baud_o == 16'(`RMB_CFG_BAUD))
    else $error("configuration rate changed");

  a_level_cap: assert property (
    tx_level_o <= 9'(`RMB_BUF_DEPTH))
    else $error("buffer level above capacity");

  a_full_refuse: assert property (
    (tx_level_o == 9'(`RMB_BUF_DEPTH)) |-> !host_ready_o)
    else $error("ready with full buffer");

  // address decisions
  a_filter_ones: assert property (
    (own_addr_i == `RMB_ADDR_ALL_ONES) |=> (!filter_en_o && bcast_tx_o && monitor_rx_o))
    else $error("all-ones address still filtered");

  a_filter_other: assert property (
    (own_addr_i != `RMB_ADDR_ALL_ONES) |=> filter_en_o)
    else $error("filter off for plain address");

  a_bcast_only: assert property (
    (own_addr_i != `RMB_ADDR_ALL_ONES) |=> !bcast_tx_o)
    else $error("broadcast for plain address");

  a_monitor_zero: assert property (
    (own_addr_i == `RMB_ADDR_ALL_ZERO) |=> (monitor_rx_o && !bcast_tx_o))
    else $error("zero address not monitoring");

  a_monitor_other: assert property (
    (own_addr_i != `RMB_ADDR_ALL_ONES && own_addr_i != `RMB_ADDR_ALL_ZERO) |=> !monitor_rx_o)
    else $error("monitor for plain address");

  // main scenarios
  c_mode_switch: cover property (
    $changed(mode_o));
  c_sleep_exit: cover property (
    state_r == rmb_pkg::RMB_ST_RELOAD);
  c_busy_rise: cover property (
    $rose(busy_n_o));
  c_host_full: cover property (
    tx_level_o == 9'(`RMB_BUF_DEPTH));
  c_cfg_wake: cover property (
    cfg_awake_o);
endmodule
`default_nettype wire

/* File: rtl/rmb_defines.svh */
/*
  timing counts and reset values of the mode and busy controller.
  assumes a 20 MHz reference clock.
*/
`ifndef RMB_DEFINES_SVH
`define RMB_DEFINES_SVH
`define RMB_CLK_HZ 20000000
`define RMB_SWITCH_US 1000
`define RMB_SETTLE_US 2000
`define RMB_SWITCH_CYC ((`RMB_SWITCH_US * (`RMB_CLK_HZ / 1000000)))
`define RMB_SETTLE_CYC ((`RMB_SETTLE_US * (`RMB_CLK_HZ / 1000000)))
`define RMB_SELFCHK_CYC 64
`define RMB_RELOAD_CYC 32
`define RMB_BUF_DEPTH 400
`define RMB_ADDR_ALL_ONES 16'hFFFF
`define RMB_ADDR_ALL_ZERO 16'h0000
`define RMB_CFG_BAUD 9600
`define RMB_MODE_RST 2'h0
`endif

/* File: rtl/rmb_pkg.sv */
/*
  types of the mode and busy controller.
  assumes nothing beyond the tool's package support.
*/
package rmb_pkg;
  // operating modes as decoded from the select pins
  typedef enum logic [1:0] {
    RMB_MODE_TRANSP = 2'h0,
    RMB_MODE_WOR_TX = 2'h1,
    RMB_MODE_WOR_RX = 2'h2,
    RMB_MODE_SLEEP = 2'h3
  } rmb_mode_e;
  // controller states, one-hot
  typedef enum logic [3:0] {
    RMB_ST_SELFCHK = 4'h1,
    RMB_ST_RUN = 4'h2,
    RMB_ST_SWITCH = 4'h4,
    RMB_ST_RELOAD = 4'h8
  } rmb_state_e;
  // pending-work flags that each pull busy low
  typedef struct packed {
    logic init;
    logic tx_pend;
    logic rx_out;
  } rmb_busy_s;
  // address filter decision
  typedef struct packed {
    logic bcast_tx;
    logic monitor_rx;
    logic filter_en;
  } rmb_addr_s;
endpackage

/* File: rtl/rmb_tx_level.sv */
/*
  occupancy counter of the transmit buffer: counts bytes written by the
  host and bytes handed to the radio.
  assumes one write and one drain strobe per clock at most.
*/
`include "rmb_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module rmb_tx_level (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic ready_o,
  output logic [8:0] level_o
);
  logic [8:0] level_r;
  logic do_wr;
  logic do_rd;
  // ==================================================
  // occupancy tracking
  assign do_wr = wr_i && (level_r < 9'(`RMB_BUF_DEPTH));
  assign do_rd = rd_i && (level_r != 9'h000);
  assign ready_o = (level_r < 9'(`RMB_BUF_DEPTH));
  assign level_o = level_r;
  // count up on write, down on drain
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_r <= 9'h000;
    end else if (do_wr && !do_rd) begin
      level_r <= level_r + 9'h001;
    end else if (do_rd && !do_wr) begin
      level_r <= level_r - 9'h001;
    end
  end
endmodule
`default_nettype wire

/* File: sim/rmb_host_model.sv */
/*
  host model: drives the two select pins and watches the busy indicator.
  assumes the bench changes want_mode_i and polite_i off the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rmb_host_model (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic busy_n_i,
  input wire logic [1:0] want_mode_i,
  input wire logic polite_i,
  output logic mode_select_low_o,
  output logic mode_select_high_o,
  output logic started_o
);
  // ==========================================
  // busy-high age and pin drive
  int unsigned age;
  // pins start in transparent mode before the first falling edge
  initial {mode_select_high_o, mode_select_low_o} = 2'h0;
  // count busy-high cycles and note the first rise after reset
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age <= 0;
      started_o <= 1'b0;
    end else begin
      age <= busy_n_i ? age + 1 : 0;
      if (busy_n_i) started_o <= 1'b1;
    end
  end
  // a polite host moves the pins only after 2 ms of busy high
  always @(negedge ref_clk_i) begin
    if (!polite_i || age >= 40000) begin
      {mode_select_high_o, mode_select_low_o} <= want_mode_i;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
/*
  testbench of the mode and busy controller with a host model.
  assumes a 20 MHz clock and the full 1 ms and 2 ms counts of the design.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk_i, arst_n_i, host_wr_i, radio_take_i, rx_out_active_i, cfg_req_i;
  logic polite, m_lo, m_hi, started, host_ready_o, busy_n_o, sleep_o, cfg_awake_o;
  logic reload_o, bcast_tx_o, monitor_rx_o, filter_en_o;
  logic [1:0] want_mode, mode_o;
  logic [8:0] tx_level_o;
  logic [15:0] own_addr_i, cfg_baud_o, a;
  int n_mismatch, checks, seed, k;
  // ==========================================
  // design and host
  rmb_ctrl u_rmb_ctrl (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .mode_select_low_i(m_lo), .mode_select_high_i(m_hi), .own_addr_i(own_addr_i),
    .host_wr_i(host_wr_i), .radio_take_i(radio_take_i), .rx_out_active_i(rx_out_active_i),
    .cfg_req_i(cfg_req_i), .host_ready_o(host_ready_o), .busy_n_o(busy_n_o),
    .mode_o(mode_o), .sleep_o(sleep_o), .cfg_awake_o(cfg_awake_o), .reload_o(reload_o),
    .tx_level_o(tx_level_o), .bcast_tx_o(bcast_tx_o), .monitor_rx_o(monitor_rx_o),
    .filter_en_o(filter_en_o), .cfg_baud_o(cfg_baud_o));
  rmb_host_model u_rmb_host_model (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .busy_n_i(busy_n_o), .want_mode_i(want_mode), .polite_i(polite),
    .mode_select_low_o(m_lo), .mode_select_high_o(m_hi), .started_o(started));
  // ==========================================
  // helpers
  function automatic logic exp_bcast(input logic [15:0] ad);
    return ad === 16'hFFFF;
  endfunction
  function automatic logic exp_mon(input logic [15:0] ad);
    return ad === 16'hFFFF || ad === 16'h0000;
  endfunction
  // 0 busy, 1 mode, 2 pins
  function automatic logic [1:0] pick(input int sel);
    return sel == 0 ? {1'b0, busy_n_o} : sel == 1 ? mode_o : {m_hi, m_lo};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for a watched value, n gives the cycles spent
  task automatic wait_on(input int sel, input logic [1:0] v, input int lim, output int n);
    n = 0;
    while (pick(sel) !== v && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("waited value", v, pick(sel));
  endtask
  // back-to-back write or drain strobes
  task automatic pulse(input int n, input bit wr);
    repeat (n) begin
      if (wr) host_wr_i = 1'b1;
      else radio_take_i = 1'b1;
      @(negedge ref_clk_i);
    end
    host_wr_i = 1'b0;
    radio_take_i = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_mismatch++;
    $display("BAD watchdog expected end seen hang");
    report_and_stop();
  end
  // ==========================================
  // tests
  initial begin
    seed = 32'hDBDD;
    {arst_n_i, host_wr_i, radio_take_i, rx_out_active_i, cfg_req_i, polite} = 6'h00;
    own_addr_i = 16'h1234;
    want_mode = 2'h0;
    repeat (4) @(negedge ref_clk_i);
    chk("busy_n_o", 16'h0, busy_n_o);
    arst_n_i = 1'b1;
    repeat (40) @(negedge ref_clk_i);
    chk("busy_n_o", 16'h0, busy_n_o);
    chk("reload_o", 16'h1, reload_o);
    wait_on(0, 2'h1, 100, k);
    wait (started === 1'b1);
    @(negedge ref_clk_i);
    chk("mode_o", 16'h0, mode_o);
    $display("test reset done");
    // special addresses first, then random ones
    for (int i = 0; i < 8; i++) begin
      a = i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : 16'($random(seed));
      own_addr_i = a;
      repeat (2) @(negedge ref_clk_i);
      chk("bcast_tx_o", exp_bcast(a), bcast_tx_o);
      chk("monitor_rx_o", exp_mon(a), monitor_rx_o);
      chk("filter_en_o", !exp_bcast(a), filter_en_o);
    end
    chk("cfg_baud_o", 16'h2580, cfg_baud_o);
    $display("test address done");
    // pending bytes and serial output each hold busy low
    k = 1 + ($unsigned($random(seed)) % 16);
    pulse(k, 1);
    chk("busy_n_o", 16'h0, busy_n_o);
    chk("tx_level_o", 16'(k), tx_level_o);
    rx_out_active_i = 1'b1;
    pulse(k, 0);
    chk("busy_n_o", 16'h0, busy_n_o);
    chk("tx_level_o", 16'h0, tx_level_o);
    rx_out_active_i = 1'b0;
    wait_on(0, 2'h1, 4, k);
    pulse(399, 1);
    chk("host_ready_o", 16'h1, host_ready_o);
    @(negedge ref_clk_i);
    pulse(2, 1);
    chk("tx_level_o", 16'h190, tx_level_o);
    chk("host_ready_o", 16'h0, host_ready_o);
    @(negedge ref_clk_i);
    pulse(400, 0);
    wait_on(0, 2'h1, 4, k);
    $display("test buffer done");
    // sleep requested while data is pending both ways
    pulse(3, 1);
    rx_out_active_i = 1'b1;
    want_mode = 2'h3;
    repeat (100) @(negedge ref_clk_i);
    chk("mode_o", 16'h0, mode_o);
    pulse(3, 0);
    repeat (50) @(negedge ref_clk_i);
    chk("mode_o", 16'h0, mode_o);
    rx_out_active_i = 1'b0;
    wait_on(0, 2'h1, 4, k);
    wait_on(1, 2'h3, 40010, k);
    chk("switch delay", 16'h1, k >= 19990);
    chk("sleep_o", 16'h1, sleep_o);
    cfg_req_i = 1'b1;
    @(negedge ref_clk_i);
    chk("cfg_awake_o", 16'h1, cfg_awake_o);
    chk("sleep_o", 16'h0, sleep_o);
    cfg_req_i = 1'b0;
    $display("test sleep done");
    // leave sleep through a polite host while idle
    polite = 1'b1;
    want_mode = 2'h0;
    wait_on(2, 2'h0, 40010, k);
    wait_on(0, 2'h0, 20010, k);
    chk("idle switch", 16'h1, k >= 19990);
    chk("reload_o", 16'h1, reload_o);
    wait_on(0, 2'h1, 40, k);
    chk("reload length", 16'h1, k >= 30);
    chk("mode_o", 16'h0, mode_o);
    $display("test wake done");
    report_and_stop();
  end
endmodule
`default_nettype wire
